/* File: shared/cfcg_pkg.sv */
package cfcg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EXPECT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_LINES = 8'h0C;
  localparam logic [7:0] OFF_WIDTH = 8'h10;
  localparam logic [7:0] OFF_OVERRUN = 8'h14;
  localparam logic [7:0] OFF_IMGCNT = 8'h18;
  // control field positions
  localparam int CTRL_REQ = 0;
  localparam int CTRL_FVDONE = 1;
  localparam int CTRL_HWCONT = 2;
  localparam int CTRL_DVUSE = 3;
  localparam int CTRL_CONT = 4;
  localparam int CTRL_EXPOSE = 5;
  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_ARMED = 1;
  localparam int STAT_DROP = 2;
  localparam int STAT_PEND_LO = 8;
  // reset values
  localparam logic [31:0] EXPECT_RST = 32'h0000_0400;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // capture states
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_CAPT, ST_OVR} cfcg_state_e;
endpackage

/* File: src/cfcg_top.sv */
// small fifo with a registered head so the read side sees flops only
module cfcg_fifo import cfcg_pkg::*; #(
  parameter int W = 17,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem [DEPTH];        // storage flops
  logic [AW-1:0] wp_r, rp_r;        // pointers
  logic [AW:0] cnt_r;               // stored entries
  logic ovld_r;                     // head register valid
  logic [W-1:0] odat_r;             // head register data
  wire do_wr = in_valid & in_ready;
  wire load = (cnt_r != '0) & (~ovld_r | out_ready);
  wire pop_only = out_ready & ovld_r & ~load;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = ovld_r;
  assign out_data = odat_r;
  // write into storage; no reset, the count says what is valid
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp_r] <= in_data;
  end
  // pointers and entry count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + AW'(1);
      if (load) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(load);
    end
  end
  // head register: refilled as soon as it drains
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovld_r <= 1'b0;
      odat_r <= '0;
    end else if (load) begin
      ovld_r <= 1'b1;
      odat_r <= mem[rp_r];
    end else if (pop_only) begin
      ovld_r <= 1'b0;
    end
  end
endmodule // cfcg_fifo

// What this block does
// RL1 - start storing at frame-valid rise after request
// RL2 - without frame-end option, end by pixel count
// RL3 - frame-end option ends image at frame-valid fall, except in hw continuous mode
// RL4 - excess data continues into next buffer
// RL5 - continuous mode: first request, then frame-valid rise
// RL6 - continuous mode: later frames by count only
// RL7 - accept pixel only with line/data valid
// RL8 - report overrun bytes, zero when none
// RL9 - expose trigger only while continuous active
// RL10 - software sets up at least one buffer
// RL11 - record lines transferred last acquisition
// RL12 - record pixels in last completed line (code also records a partial line when the image ends mid-line)
// RL13 - one-cycle image-complete pulse at image end
module cfcg_top import cfcg_pkg::*; #(
  parameter int PW = 16,   // pixel width
  parameter int CW = 24,   // counter width
  parameter int BPP = 2,   // bytes per pixel for overrun figure
  parameter int DEPTH = 32 // fifo depth
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // camera pins
  input wire logic cam_fval,
  input wire logic cam_lval,
  input wire logic cam_dval,
  input wire logic [PW-1:0] cam_data,
  output logic cam_expose,
  // dma side
  output logic dma_valid,
  input wire logic dma_ready,
  output logic [PW-1:0] dma_data,
  output logic dma_last,
  output logic img_done
);
  if (PW < 1 || PW > 31 || CW < 8 || CW > 32 || BPP < 1 || BPP > 4) begin : g_bad
    $error("unsupported pixel or counter width");
  end
  localparam int SW = PW + 3;
  // unsigned zero-extend to a bus word
  function automatic logic [31:0] zx(input logic [CW-1:0] v);
    return {{(32-CW){1'b0}}, v};
  endfunction
  logic [SW-1:0] s1_r, s2_r, s3_r;  // three stages, s1 feeds s2 only
  logic fv_r, lv_r, dv_r;           // filtered qualifiers
  logic fv_d_r, lv_d_r;             // previous filtered values
  logic [PW-1:0] pix_r;             // data aligned with filtered qualifiers
  // a change is taken once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {s3_r, s2_r, s1_r} <= '0;
    end else begin
      {s3_r, s2_r, s1_r} <= {s2_r, s1_r, cam_fval, cam_lval, cam_dval, cam_data};
    end
  end
  wire [2:0] q_agree = s2_r[SW-1:PW] ~^ s3_r[SW-1:PW];
  // filter stage: each qualifier moves only on agreement
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {fv_r, lv_r, dv_r} <= 3'h0;
      {fv_d_r, lv_d_r} <= 2'h0;
      pix_r <= '0;
    end else begin
      if (q_agree[2]) fv_r <= s3_r[SW-1];
      if (q_agree[1]) lv_r <= s3_r[SW-2];
      if (q_agree[0]) dv_r <= s3_r[SW-3];
      {fv_d_r, lv_d_r} <= {fv_r, lv_r};
      pix_r <= s3_r[PW-1:0];
    end
  end
  wire fv_rise = fv_r & ~fv_d_r;
  wire fv_fall = ~fv_r & fv_d_r;
  wire lv_fall = ~lv_r & lv_d_r;
  logic fvd_en_r, hw_en_r, dvu_en_r, cont_en_r; // control bits
  logic [CW-1:0] expect_r;                      // expected pixels per image
  logic [7:0] pend_r;                           // queued requests
  logic drop_r;                                 // pixel lost to full fifo, sticky
  logic [CW-1:0] lines_last_r, width_last_r, ovr_last_r, imgcnt_r; // last image results and image counter
  logic pready_r, pslverr_r, expose_r;
  logic [31:0] prdata_r;
  cfcg_state_e st_r, st_nxt;
  wire acc = psel & penable;
  wire wr_ok = acc & pready_r & pwrite & ~pslverr_r;
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_exp = (paddr == OFF_EXPECT);
  wire hit_stat = (paddr == OFF_STATUS);
  wire mapped = hit_ctrl | hit_exp | hit_stat | (paddr == OFF_LINES) |
                (paddr == OFF_WIDTH) | (paddr == OFF_OVERRUN) | (paddr == OFF_IMGCNT);
  wire req_wr = wr_ok & hit_ctrl & pwdata[CTRL_REQ];
  wire exp_wr = wr_ok & hit_ctrl & pwdata[CTRL_EXPOSE];
  wire drop_clr = wr_ok & hit_stat & pwdata[STAT_DROP];
  wire [31:0] stat_word = {16'h0000, pend_r, 5'h00, drop_r, (st_r == ST_ARM), (st_r != ST_IDLE)};
  wire [31:0] ctrl_word = {27'h0, cont_en_r, dvu_en_r, hw_en_r, fvd_en_r, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_exp ? zx(expect_r) :
                       hit_stat ? stat_word :
                       (paddr == OFF_LINES) ? zx(lines_last_r) :
                       (paddr == OFF_WIDTH) ? zx(width_last_r) :
                       (paddr == OFF_OVERRUN) ? zx(ovr_last_r) :
                       (paddr == OFF_IMGCNT) ? zx(imgcnt_r) : 32'h0000_0000;
  // apb answer: one wait state, error on unmapped address; the expose pulse
  // is refused outside continuous acquisition
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      expose_r <= 1'b0;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~mapped;
      prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_mux : 32'h0000_0000;
      expose_r <= exp_wr & cont_en_r; // RL9
    end
  end
  // software-written configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {cont_en_r, dvu_en_r, hw_en_r, fvd_en_r} <= CTRL_RST;
      expect_r <= EXPECT_RST[CW-1:0];
    end else if (wr_ok & hit_ctrl) begin
      {cont_en_r, dvu_en_r, hw_en_r, fvd_en_r} <= pwdata[CTRL_CONT:CTRL_FVDONE];
    end else if (wr_ok & hit_exp) begin
      expect_r <= pwdata[CW-1:0];
    end
  end
  logic [CW-1:0] pix_cnt_r, line_pix_r, line_cnt_r, ovr_cnt_r; // capture counters
  logic done_r, fifo_rdy; // completion pulse, fifo space
  wire active = (st_r == ST_CAPT) | (st_r == ST_OVR);
  wire qual = lv_r & (dv_r | ~dvu_en_r);          // RL7
  wire accept = active & qual;
  wire push = accept & fifo_rdy;                    // full fifo drops the pixel
  wire [CW-1:0] pix_inc = pix_cnt_r + CW'(1);
  wire cnt_hit = (st_r == ST_CAPT) & push & (pix_inc == expect_r); // RL2
  wire fv_hit = (st_r == ST_CAPT) & fv_fall & fvd_en_r & ~hw_en_r;   // RL3
  wire img_end = cnt_hit | fv_hit;
  wire start = (st_r == ST_ARM) & fv_rise;          // RL1 RL5
  wire [CW-1:0] lp_nxt = push ? line_pix_r + CW'(1) : line_pix_r;
  wire line_end = active & lv_fall & (line_pix_r != '0);
  // next capture state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (pend_r != 8'h00) st_nxt = ST_ARM;
      ST_ARM: if (start) st_nxt = ST_CAPT; // RL1
      ST_CAPT: begin
        if (img_end) begin
          if (hw_en_r) st_nxt = ST_CAPT;               // RL6
          else if (fv_r & ~fv_hit) st_nxt = ST_OVR;    // RL4
          else if (pend_r != 8'h00) st_nxt = ST_ARM;
          else st_nxt = ST_IDLE;
        end
      end
      ST_OVR: begin
        // excess keeps flowing out until the frame closes
        if (~fv_r) st_nxt = (pend_r != 8'h00) ? ST_ARM : ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  // state and request queue; a request and a start together cancel out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      pend_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (req_wr & ~start & (pend_r != 8'hFF)) pend_r <= pend_r + 8'h01;
      else if (start & ~req_wr) pend_r <= pend_r - 8'h01;
    end
  end
  // pixel counter, restarted per image
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pix_cnt_r <= '0;
    end else if (start | img_end) begin
      pix_cnt_r <= '0;
    end else if (push & (st_r == ST_CAPT)) begin
      pix_cnt_r <= pix_inc;
    end
  end
  // line bookkeeping for line scan use
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_pix_r <= '0;
      line_cnt_r <= '0;
      width_last_r <= '0;
      lines_last_r <= '0;
    end else if (img_end) begin
      lines_last_r <= line_cnt_r + CW'(lp_nxt != '0); // RL11
      if (lp_nxt != '0) width_last_r <= lp_nxt;       // RL12
      line_pix_r <= '0;
      line_cnt_r <= '0;
    end else if (line_end) begin
      width_last_r <= line_pix_r; // RL12
      line_cnt_r <= line_cnt_r + CW'(1);
      line_pix_r <= '0;
    end else if (start) begin
      line_pix_r <= '0;
      line_cnt_r <= '0;
    end else begin
      line_pix_r <= lp_nxt;
    end
  end
  // overrun: bytes past the expected count, zero when the frame ended on time
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovr_cnt_r <= '0;
      ovr_last_r <= '0;
    end else if (img_end) begin
      ovr_cnt_r <= '0;
      ovr_last_r <= '0; // RL8
    end else if (st_r == ST_OVR) begin
      if (push) ovr_cnt_r <= ovr_cnt_r + CW'(BPP); // RL4
      if (~fv_r) ovr_last_r <= ovr_cnt_r;          // RL8
    end
  end
  // completion pulse, image counter, lost-pixel flag (set beats clear)
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      imgcnt_r <= '0;
      drop_r <= 1'b0;
    end else begin
      done_r <= img_end; // RL13
      if (img_end) imgcnt_r <= imgcnt_r + CW'(1);
      if (accept & ~fifo_rdy) drop_r <= 1'b1;
      else if (drop_clr) drop_r <= 1'b0;
    end
  end
  // fifo head: last flag and pixel, straight from the head register
  logic [PW:0] fifo_q;
  cfcg_fifo #(.W(PW + 1), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data({cnt_hit, pix_r}),
    .out_valid(dma_valid),
    .out_ready(dma_ready),
    .out_data(fifo_q)
  );
  assign {dma_last, dma_data} = fifo_q;
  assign img_done = done_r;
  assign cam_expose = expose_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  // checks on the capture gating
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_start;
    (st_r == ST_ARM) && fv_rise |=> (st_r == ST_CAPT);
  endproperty
  a_start: assert property (p_start) else $error("capture did not start"); // RL1
  property p_wait;
    (st_r == ST_ARM) && !fv_rise |=> (st_r != ST_CAPT);
  endproperty
  a_wait: assert property (p_wait) else $error("capture began without rise"); // RL5
  property p_count_end;
    cnt_hit |=> done_r && (pix_cnt_r == '0);
  endproperty
  a_count_end: assert property (p_count_end) else $error("count end missed"); // RL2
  property p_fv_ignored;
    (st_r == ST_CAPT) && fv_fall && !fvd_en_r && !cnt_hit |=> !done_r;
  endproperty
  a_fv_ignored: assert property (p_fv_ignored) else $error("fval fall ended image"); // RL2
  property p_fv_end;
    (st_r == ST_CAPT) && fv_fall && fvd_en_r && !hw_en_r |=> done_r ##1 !done_r;
  endproperty
  a_fv_end: assert property (p_fv_end) else $error("frame end not honoured"); // RL3
  property p_hw_stay;
    (st_r == ST_CAPT) && img_end && hw_en_r |=> (st_r == ST_CAPT);
  endproperty
  a_hw_stay: assert property (p_hw_stay) else $error("hw mode left capture"); // RL6
  property p_gate;
    push |-> lv_r && (dv_r || !dvu_en_r);
  endproperty
  a_gate: assert property (p_gate) else $error("pixel taken without valids"); // RL7
  property p_ovr;
    (st_r == ST_OVR) && push |=> ovr_cnt_r == $past(ovr_cnt_r) + CW'(BPP);
  endproperty
  a_ovr: assert property (p_ovr) else $error("excess not counted"); // RL4
  property p_ovr_zero;
    done_r |-> (ovr_last_r == '0);
  endproperty
  a_ovr_zero: assert property (p_ovr_zero) else $error("overrun not cleared"); // RL8
  property p_expose;
    cam_expose |-> $past(cont_en_r);
  endproperty
  a_expose: assert property (p_expose) else $error("expose outside continuous"); // RL9
  c_hw: cover property ((st_r == ST_CAPT) && img_end && hw_en_r);
  c_fv: cover property (fv_hit);
  c_ovr: cover property ((st_r == ST_OVR) ##1 (st_r != ST_OVR));
  c_drop: cover property (accept && !fifo_rdy);
endmodule // cfcg_top

/* File: tb/cfcg_cam_model.sv */
// camera model: valid strobes and pixel bus, driven just after the rising edge
module cfcg_cam_model (
  // clock
  input wire logic clk,
  // camera pins
  output logic cam_fval,
  output logic cam_lval,
  output logic cam_dval,
  output logic [15:0] cam_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cam_fval = 1'b0;
    cam_lval = 1'b0;
    cam_dval = 1'b0;
    cam_data = 16'h0000;
  end
  // data changes every cycle so an idle bus never shows a stale pixel
  always @(posedge clk) cam_data <= cam_data + 16'h0001;
  // one frame; gaps of at least 4 cycles survive the qualifier filter
  task frame(input int lines, input int width, input bit fv, input bit gap);
    int n;
    begin
      cam_fval <= fv;
      repeat (6) @(posedge clk);
      for (int l = 0; l < lines; l++) begin
        n = gap ? 2 * width : width;
        for (int i = 0; i < n; i++) begin
          cam_lval <= 1'b1;
          cam_dval <= gap ? ((i % 8) < 4) : 1'b1;
          @(posedge clk);
        end
        cam_lval <= 1'b0;
        cam_dval <= 1'b0;
        repeat (5) @(posedge clk);
      end
      cam_fval <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // cfcg_cam_model

/* File: tb/tb.sv */
// self-checking bench for the capture gating block
module tb;
  import cfcg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic cam_fval, cam_lval, cam_dval, cam_expose;
  logic [15:0] cam_data, dma_data;
  logic dma_valid, dma_ready, dma_last, img_done, e;
  logic [31:0] cam_sum, dma_sum; // pixel sums at the pins and at the dma side
  int miscompares = 0;
  int checks_done = 0;
  int n_done, n_last, n_pix, n_exp;
  cfcg_top cfcg_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cam_fval(cam_fval), .cam_lval(cam_lval), .cam_dval(cam_dval),
    .cam_data(cam_data), .cam_expose(cam_expose), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_data(dma_data), .dma_last(dma_last), .img_done(img_done));
  cfcg_cam_model cam_inst (.clk(clk), .cam_fval(cam_fval), .cam_lval(cam_lval),
    .cam_dval(cam_dval), .cam_data(cam_data));
  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // event counters at the camera pins, on the dma side and at the camera trigger
  always @(posedge clk) begin
    if (img_done === 1'b1) n_done++;
    if (cam_lval === 1'b1 && cam_dval === 1'b1) cam_sum += cam_data;
    if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
      n_pix++;
      dma_sum += dma_data;
    end
    if (dma_valid === 1'b1 && dma_ready === 1'b1 && dma_last === 1'b1) n_last++;
    if (cam_expose === 1'b1) n_exp++;
  end
  // verdict
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // compare one value
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      chk("pready_wait", 32'h2, n);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  // read and compare under a mask
  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
            input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp & m, q & m);
  endtask
  task clr;
    n_done = 0;
    n_last = 0;
    n_pix = 0;
    n_exp = 0;
    cam_sum = 32'h0;
    dma_sum = 32'h0;
  endtask
  // reset values and an unmapped offset
  task s_reset;
    rchk("expect_rst", OFF_EXPECT, EXPECT_RST, 32'hFFFF_FFFF);
    rchk("ctrl_rst", OFF_CTRL, 32'h0, 32'hFFFF_FFFF);
    rchk("status_rst", OFF_STATUS, 32'h0, 32'hFFFF_FFFF);
    apb(1'b1, 8'h1C, 32'h0000_0055);
    chk("unmapped_wr_err", 32'h1, {31'h0, e});
    rchk("unmapped_rd", 8'h1C, 32'h0, 32'hFFFF_FFFF);
    chk("unmapped_rd_err", 32'h1, {31'h0, e});
  endtask
  // frame before any request is ignored; then count end with 4 excess pixels
  task s_count;
    clr();
    apb(1'b1, OFF_EXPECT, 32'h0000_0010);
    cam_inst.frame(2, 4, 1'b1, 1'b0);
    chk("no_req_pixels", 32'h0, n_pix);
    clr();
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    rchk("armed", OFF_STATUS, 32'h2, 32'h2);
    cam_inst.frame(5, 4, 1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk("img_done_cnt", 32'h1, n_done);
    chk("last_cnt", 32'h1, n_last);
    chk("pix_cnt", 32'd20, n_pix);
    chk("pix_sum", cam_sum, dma_sum);
    rchk("lines", OFF_LINES, 32'h4, 32'hFFFF_FFFF);
    rchk("width", OFF_WIDTH, 32'h4, 32'hFFFF_FFFF);
    rchk("overrun", OFF_OVERRUN, 32'h8, 32'hFFFF_FFFF);
    rchk("imgcnt", OFF_IMGCNT, 32'h1, 32'hFFFF_FFFF);
  endtask
  // frame-valid ends a short image early
  task s_fvdone;
    clr();
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    apb(1'b1, OFF_EXPECT, 32'h0000_0064);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    cam_inst.frame(3, 5, 1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk("fv_done_cnt", 32'h1, n_done);
    chk("fv_last_cnt", 32'h0, n_last);
    chk("fv_pix", 32'd15, n_pix);
    rchk("fv_lines", OFF_LINES, 32'h3, 32'hFFFF_FFFF);
    rchk("fv_width", OFF_WIDTH, 32'h5, 32'hFFFF_FFFF);
    rchk("fv_overrun", OFF_OVERRUN, 32'h0, 32'hFFFF_FFFF);
  endtask
  // expose trigger refused without continuous, accepted with it
  task s_expose;
    clr();
    apb(1'b1, OFF_CTRL, 32'h0000_0020);
    repeat (4) @(posedge clk);
    chk("expose_off", 32'h0, n_exp);
    apb(1'b1, OFF_CTRL, 32'h0000_0010);
    apb(1'b1, OFF_CTRL, 32'h0000_0030);
    repeat (4) @(posedge clk);
    chk("expose_on", 32'h1, n_exp);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
  endtask
  // dma stalls: fifo fills, pixels drop, flag is sticky until written
  task s_fifo;
    clr();
    dma_ready <= 1'b0;
    apb(1'b1, OFF_EXPECT, 32'h0000_0028);
    // frame end closes the image, since lost pixels keep the count short
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    cam_inst.frame(5, 8, 1'b1, 1'b0);
    rchk("drop_set", OFF_STATUS, 32'h4, 32'h4);
    dma_ready <= 1'b1;
    repeat (80) @(posedge clk);
    chk("fifo_bounded", 32'h1, {31'h0, (n_pix < 40 && n_pix >= 32)});
    chk("fifo_done", 32'h1, n_done);
    apb(1'b1, OFF_STATUS, 32'h0000_0004);
    rchk("drop_clr", OFF_STATUS, 32'h0, 32'h4);
  endtask
  // hardware continuous with data-valid gating; later images by count only
  task s_hw;
    clr();
    apb(1'b1, OFF_EXPECT, 32'h0000_0008);
    apb(1'b1, OFF_CTRL, 32'h0000_000C);
    cam_inst.frame(4, 4, 1'b1, 1'b1);
    chk("hw_first_none", 32'h0, n_done);
    clr();
    apb(1'b1, OFF_CTRL, 32'h0000_000D);
    cam_inst.frame(4, 4, 1'b1, 1'b1);
    repeat (30) @(posedge clk);
    chk("hw_done2", 32'h2, n_done);
    cam_inst.frame(2, 4, 1'b0, 1'b1);
    repeat (30) @(posedge clk);
    chk("hw_done3", 32'h3, n_done);
    chk("hw_last", 32'h3, n_last);
    chk("hw_pix", 32'd24, n_pix);
    chk("hw_sum", cam_sum, dma_sum);
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dma_ready = 1'b1;
    clr();
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_count();
    s_fvdone();
    s_expose();
    s_fifo();
    s_hw();
    test_done();
  end
  // watchdog: the whole run needs under a thousand cycles, the limit is 25000
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
endmodule // tb
